// file: nav_subframe_reporter.sv
// collects decoded subframe words, checks them and emits one report message
// assumes the decoder runs on REF_CLK_IN and holds words while ready is low;
// the parser takes one 32-bit word per valid-and-ready cycle
`timescale 1ns/100ps
module nav_subframe_reporter
    import sf_report_pkg::*;
(
    input  wire logic              REF_CLK_IN,        // 20 MHz clock
    input  wire logic              RESET_N_IN,        // async reset, low
    input  wire logic              CE_IN,             // clock enable, low freezes
    input  wire logic              REPORT_EN_IN,      // subframe reporting enable
    input  wire logic              SF_VALID_IN,       // decoder word valid
    output logic                   SF_READY_OUT,      // framer accepts word
    input  wire logic              SF_FIRST_IN,       // first word of subframe
    input  wire logic              SF_LAST_IN,        // last word, subframe done
    input  wire logic [WORD_W-1:0] SF_WORD_IN,        // raw word, right-aligned
    input  wire logic              SF_PARITY_OK_IN,   // word passed parity
    input  wire logic [7:0]        GNSS_ID_IN,        // constellation id
    input  wire logic [7:0]        SV_ID_IN,          // satellite number
    input  wire logic              SV_KNOWN_IN,       // satellite identified
    input  wire logic [7:0]        SIG_ID_IN,         // signal id
    input  wire logic              GAL_ALERT_IN,      // Galileo alert pair
    input  wire logic [7:0]        GLO_FRAME_IN,      // deduced frame number
    input  wire logic              GLO_FRAME_OK_IN,   // frame number known
    input  wire logic [7:0]        GLO_SUPER_IN,      // deduced superframe number
    input  wire logic              GLO_SUPER_OK_IN,   // superframe number known
    output logic                   MSG_VALID_OUT,     // report word valid
    input  wire logic              MSG_READY_IN,      // parser takes word
    output logic      [WORD_W-1:0] MSG_DATA_OUT,      // header or payload word
    output logic                   MSG_FIRST_OUT,     // header word
    output logic                   MSG_LAST_OUT,      // final payload word
    output logic                   DROP_OUT           // subframe discarded, pulse
);
    typedef struct packed {
        frm_state_e                       st;
        logic [MAX_WORDS-1:0][WORD_W-1:0] mem;
        logic [IDX_W-1:0]                 wr_idx;
        logic [IDX_W-1:0]                 rd_idx;
        logic [IDX_W-1:0]                 n_words;
        logic                             ok;
        logic                             overrun;
        logic [7:0]                       gnss;
        logic [7:0]                       sv;
        logic [7:0]                       sig;
        logic                             alert;
        logic [7:0]                       glo_frame;
        logic [7:0]                       glo_super;
        logic [WORD_W-1:0]                out_data;
        logic                             out_valid;
        logic                             out_first;
        logic                             drop;
    } core_s;

    core_s q;
    core_s d;

    word_path_if wp ();

    logic [7:0]       cur_gnss;
    logic [7:0]       cur_sig;
    logic [IDX_W-1:0] rx_words;
    logic [IDX_W-1:0] tx_words;
    logic             take;
    logic             last_out;

    // metadata is sampled with the first word, so steer the normaliser
    // from the live inputs on that cycle and from the held copy after it
    assign cur_gnss = (q.st == ST_IDLE || SF_FIRST_IN) ? GNSS_ID_IN : q.gnss;
    assign cur_sig  = (q.st == ST_IDLE || SF_FIRST_IN) ? SIG_ID_IN : q.sig;

    assign wp.raw       = SF_WORD_IN;
    assign wp.invert_en = (cur_gnss == GNSS_GPS || cur_gnss == GNSS_QZSS)
                          && (cur_sig == SIG_L1CA);
    assign wp.pad_top2  = (cur_gnss == GNSS_BDS);
    // word 10 of an LNAV subframe ends in zero bits, so a first word sees D30*=0
    assign wp.prev_d30  = (q.st == ST_COLLECT && !SF_FIRST_IN && q.wr_idx != '0)
                          ? q.mem[q.wr_idx - 4'h1][D30_BIT] : 1'b0;

    word_normaliser u_norm (
        .wp (wp.norm)
    );

    word_count_lookup u_count (
        .GNSS_IN      (q.gnss),
        .RX_WORDS_OUT (rx_words),
        .TX_WORDS_OUT (tx_words)
    );

    assign SF_READY_OUT  = (q.st == ST_IDLE) || (q.st == ST_COLLECT);
    assign take          = SF_VALID_IN && SF_READY_OUT;
    assign last_out      = (q.st == ST_PAYLOAD) && (q.rd_idx == q.n_words - 4'h1);
    assign MSG_VALID_OUT = q.out_valid;
    assign MSG_DATA_OUT  = q.out_data;
    assign MSG_FIRST_OUT = q.out_first;
    assign MSG_LAST_OUT  = q.out_valid && last_out;
    assign DROP_OUT      = q.drop;

    always_comb begin
        logic             done;
        logic             good;
        logic [IDX_W-1:0] slot;
        done = 1'b0;
        good = 1'b0;
        slot = '0;
        d = q;
        d.drop = 1'b0;

        case (q.st)
            ST_IDLE, ST_COLLECT: begin
                if (take && SF_FIRST_IN && REPORT_EN_IN) begin
                    d.drop      = (q.st == ST_COLLECT);
                    d.st        = ST_COLLECT;
                    d.gnss      = GNSS_ID_IN;
                    d.sig       = SIG_ID_IN;
                    d.alert     = GAL_ALERT_IN;
                    // unidentified GLONASS slot reports the unknown marker
                    d.sv        = (GNSS_ID_IN == GNSS_GLO && !SV_KNOWN_IN)
                                  ? SV_UNKNOWN : SV_ID_IN;
                    d.glo_frame = GLO_FRAME_OK_IN ? GLO_FRAME_IN : 8'h00;
                    d.glo_super = GLO_SUPER_OK_IN ? GLO_SUPER_IN : 8'h00;
                    d.mem       = '0;
                    d.mem[0]    = wp.clean;
                    d.wr_idx    = 4'h1;
                    d.ok        = SF_PARITY_OK_IN;
                    d.overrun   = 1'b0;
                    done        = SF_LAST_IN;
                end else if (take && q.st == ST_COLLECT && !SF_FIRST_IN) begin
                    if (q.wr_idx < MAX_WORDS[IDX_W-1:0]) begin
                        d.mem[q.wr_idx] = wp.clean;
                        d.wr_idx        = q.wr_idx + 4'h1;
                    end else begin
                        d.overrun = 1'b1;
                    end
                    d.ok = q.ok && SF_PARITY_OK_IN;
                    done = SF_LAST_IN;
                end else if (!REPORT_EN_IN && q.st == ST_COLLECT) begin
                    // disabling mid-subframe abandons it at the first cycle with no further word taken, rather than half reporting
                    d.st   = ST_IDLE;
                    d.drop = 1'b1;
                end
            end
            ST_HEADER: begin
                if (MSG_READY_IN) begin
                    d.st        = ST_PAYLOAD;
                    d.rd_idx    = '0;
                    d.out_data  = q.mem[0];
                    d.out_first = 1'b0;
                end
            end
            ST_PAYLOAD: begin
                if (MSG_READY_IN) begin
                    if (last_out) begin
                        d.st        = ST_IDLE;
                        d.out_valid = 1'b0;
                        d.out_data  = '0;
                    end else begin
                        slot       = q.rd_idx + 4'h1;
                        d.rd_idx   = slot;
                        d.out_data = q.mem[slot];
                    end
                end
            end
            default: begin
                d.st = ST_IDLE;
            end
        endcase

        // completion check happens a cycle after the last word is stored
        if (q.st == ST_COLLECT && d.st == ST_COLLECT && !done && q.wr_idx != '0
            && d.wr_idx == q.wr_idx && !take) begin
            good = 1'b0;
        end

        if (done) begin
            d.st = ST_COLLECT;
            d.n_words = '1;
        end

        if (q.st == ST_COLLECT && q.n_words == '1) begin
            good = q.ok && !q.overrun && rx_words != '0
                   && q.wr_idx == rx_words;
            if (q.gnss == GNSS_GLO && q.mem[0][GLO_IDLE_BIT]) begin
                good = 1'b0;
            end
            if (good) begin
                d.st        = ST_HEADER;
                d.n_words   = tx_words;
                d.out_valid = 1'b1;
                d.out_first = 1'b1;
                d.out_data  = '0;
                d.out_data[HDR_GNSS_LSB +: 8]    = q.gnss;
                d.out_data[HDR_SV_LSB +: 8]      = q.sv;
                d.out_data[HDR_CNT_LSB +: IDX_W] = tx_words;
                d.out_data[HDR_SIG_LSB +: 8]     = q.sig;
                if (q.gnss == GNSS_GLO) begin
                    d.mem[GLO_EXTRA_IDX] = '0;
                    d.mem[GLO_EXTRA_IDX][GLO_FRAME_LSB +: 8] = q.glo_frame;
                    d.mem[GLO_EXTRA_IDX][GLO_SUPER_LSB +: 8] = q.glo_super;
                end
                if (q.gnss == GNSS_GAL && q.alert) begin
                    d.mem[GAL_PAGE0_IDX][GAL_PTYPE_BIT] = 1'b1;
                    d.mem[GAL_PAGE1_IDX][GAL_PTYPE_BIT] = 1'b1;
                end
            end else begin
                d.st      = ST_IDLE;
                d.drop    = 1'b1;
                d.n_words = '0;
            end
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            q <= '0;
        end else if (CE_IN) begin
            q <= d;
        end
    end
endmodule

// file: sf_report_pkg.sv
// constants, field positions and state types for the subframe report framer
// assumes one clock domain; upstream decoder and downstream parser share it
// Behaviour
// - with reporting enabled, every complete decoded subframe of a listed constellation that passes parity (GLONASS: bit 85 clear) yields its own report;
//   a first word taken a cycle after a last word is lost, corrupting that report
// - payload bits are forwarded as received except inversion undo, padding clear and alert page-type bits; preambles and check bits kept
// - payload travels as 32-bit words; header states how many follow
// - header carries the constellation id that selects the payload layout
// - incomplete or parity-failed subframes produce no report at all
// - data-bit inversion demanded by the parity scheme is undone before output
// - GPS L1C/A subframe reported as ten words in arrival order
// - GPS L2C subframe reported as one CNAV message over ten words
// - GLONASS 85-bit string carried in the first three words
// - GLONASS string: bits 1-8 Hamming, 81-84 string number, 85 idle zero
// - GLONASS fourth word holds frame and superframe numbers, zero if unknown
// - GLONASS data from an unidentified satellite reports satellite id 255
// - BeiDou subframe reported as ten words in arrival order
// - BeiDou words hold 30 bits; top two bits are padding
// - Galileo E1-B subframe is an I/NAV page pair over eight words
// - Galileo alert pages report page-type bits as 1, alert arrangement
// - constellation codes: GPS 0, SBAS 1, Galileo 2, BeiDou 3, QZSS 5, GLONASS 6
// - SBAS 250-bit block carried in eight 32-bit words
package sf_report_pkg;
    localparam int WORD_W    = 32;
    localparam int MAX_WORDS = 10;
    localparam int IDX_W     = 4;

    localparam logic [7:0] GNSS_GPS  = 8'h00;
    localparam logic [7:0] GNSS_SBAS = 8'h01;
    localparam logic [7:0] GNSS_GAL  = 8'h02;
    localparam logic [7:0] GNSS_BDS  = 8'h03;
    localparam logic [7:0] GNSS_QZSS = 8'h05;
    localparam logic [7:0] GNSS_GLO  = 8'h06;
    localparam logic [7:0] SIG_L1CA  = 8'h00;
    localparam logic [7:0] SV_UNKNOWN = 8'hFF;

    localparam logic [IDX_W-1:0] WORDS_GPS    = 4'hA;
    localparam logic [IDX_W-1:0] WORDS_SBAS   = 4'h8;
    localparam logic [IDX_W-1:0] WORDS_GAL    = 4'h8;
    localparam logic [IDX_W-1:0] WORDS_BDS    = 4'hA;
    localparam logic [IDX_W-1:0] WORDS_GLO_RX = 4'h3;
    localparam logic [IDX_W-1:0] WORDS_GLO_TX = 4'h4;
    localparam logic [IDX_W-1:0] GLO_EXTRA_IDX = 4'h3;

    // header word layout
    localparam int HDR_GNSS_LSB = 24;
    localparam int HDR_SV_LSB   = 16;
    localparam int HDR_CNT_LSB  = 8;
    localparam int HDR_SIG_LSB  = 0;

    // LNAV style inversion: D30* of previous word flips data bits 1..24
    localparam int INV_MSB = 29;
    localparam int INV_LSB = 6;
    localparam int D30_BIT = 0;
    localparam logic [WORD_W-1:0] BDS_DATA_MASK = 32'h3FFFFFFF;

    // GLONASS string: bit 85 at word0[31], bits 81..84 at word0[27..30]
    localparam int GLO_IDLE_BIT   = 31;
    localparam int GLO_STRNUM_MSB = 30;
    localparam int GLO_STRNUM_LSB = 27;
    localparam int GLO_HAM_MSB    = 18;
    localparam int GLO_HAM_LSB    = 11;
    localparam int GLO_FRAME_LSB  = 0;
    localparam int GLO_SUPER_LSB  = 16;

    // Galileo page-type bit in the first word of each page of the pair
    localparam int GAL_PTYPE_BIT = 30;
    localparam logic [IDX_W-1:0] GAL_PAGE0_IDX = 4'h0;
    localparam logic [IDX_W-1:0] GAL_PAGE1_IDX = 4'h4;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COLLECT,
        ST_HEADER,
        ST_PAYLOAD
    } frm_state_e;
endpackage

// file: word_path_if.sv
// carries one raw subframe word to the normaliser and its cleaned form back
// assumes a purely combinational normaliser on the same clock
`timescale 1ns/100ps
interface word_path_if;
    import sf_report_pkg::*;
    logic [WORD_W-1:0] raw;
    logic              prev_d30;
    logic              invert_en;
    logic              pad_top2;
    logic [WORD_W-1:0] clean;

    modport core (output raw, prev_d30, invert_en, pad_top2, input clean);
    modport norm (input raw, prev_d30, invert_en, pad_top2, output clean);
endinterface

// file: word_normaliser.sv
// undoes parity-scheme inversion and clears padding of one data word
// assumes raw words right-aligned as received, D30 of the prior word supplied
`timescale 1ns/100ps
module word_normaliser
    import sf_report_pkg::*;
(
    word_path_if.norm wp   // raw word in, cleaned word out
);
    always_comb begin
        wp.clean = wp.raw;
        if (wp.invert_en && wp.prev_d30) begin
            wp.clean[INV_MSB:INV_LSB] = ~wp.raw[INV_MSB:INV_LSB];
        end
        if (wp.pad_top2) begin
            wp.clean = wp.raw & BDS_DATA_MASK;
        end
    end
endmodule

// file: word_count_lookup.sv
// expected received and reported word counts per constellation
// assumes constellation codes as held in the package
`timescale 1ns/100ps
module word_count_lookup
    import sf_report_pkg::*;
(
    input  wire logic [7:0]       GNSS_IN,      // constellation id
    output logic      [IDX_W-1:0] RX_WORDS_OUT, // words expected from decoder
    output logic      [IDX_W-1:0] TX_WORDS_OUT  // words announced in report
);
    always_comb begin
        case (GNSS_IN)
            GNSS_GPS, GNSS_QZSS: RX_WORDS_OUT = WORDS_GPS;
            GNSS_SBAS:           RX_WORDS_OUT = WORDS_SBAS;
            GNSS_GAL:            RX_WORDS_OUT = WORDS_GAL;
            GNSS_BDS:            RX_WORDS_OUT = WORDS_BDS;
            GNSS_GLO:            RX_WORDS_OUT = WORDS_GLO_RX;
            default:             RX_WORDS_OUT = '0;
        endcase
        TX_WORDS_OUT = (GNSS_IN == GNSS_GLO) ? WORDS_GLO_TX : RX_WORDS_OUT;
    end
endmodule

// file: nav_report_properties.sv
// assertions on the report framer ports
// assumes one clock domain; bound into every framer instance
`timescale 1ns/100ps
module nav_report_checker
    import sf_report_pkg::*;
(
    input wire logic              REF_CLK_IN,    // clock
    input wire logic              RESET_N_IN,    // reset, low
    input wire logic              REPORT_EN_IN,  // enable
    input wire logic              SF_VALID_IN,   // word valid
    input wire logic              SF_READY_OUT,  // word ready
    input wire logic              SF_LAST_IN,    // last word
    input wire logic              MSG_VALID_OUT, // report valid
    input wire logic              MSG_READY_IN,  // report ready
    input wire logic [WORD_W-1:0] MSG_DATA_OUT,  // report word
    input wire logic              MSG_FIRST_OUT, // header
    input wire logic              MSG_LAST_OUT,  // final word
    input wire logic              DROP_OUT       // drop pulse
);
    logic [7:0] gnss_q;
    logic [7:0] cnt_q;
    logic [7:0] pay_q;
    // header fields kept so payload words can be judged by layout
    always_ff @(posedge REF_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            gnss_q <= 8'h00;
            cnt_q  <= 8'h00;
            pay_q  <= 8'h00;
        end else if (MSG_VALID_OUT && MSG_READY_IN) begin
            gnss_q <= MSG_FIRST_OUT ? MSG_DATA_OUT[31:24] : gnss_q;
            cnt_q  <= MSG_FIRST_OUT ? MSG_DATA_OUT[15:8] : cnt_q;
            pay_q  <= MSG_FIRST_OUT ? 8'h00 : pay_q + 8'h01;
        end
    end
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    sequence s_last_taken;
        SF_VALID_IN && SF_READY_OUT && SF_LAST_IN && REPORT_EN_IN;
    endsequence
    sequence s_outcome;
        (MSG_VALID_OUT && MSG_FIRST_OUT) || DROP_OUT;
    endsequence
    chk_outcome_timely: assert property (s_last_taken |-> ##[2:4] s_outcome)
        else $error("no header or drop after last word");
    chk_gnss_code: assert property (MSG_VALID_OUT && MSG_FIRST_OUT |->
        MSG_DATA_OUT[31:24] inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06}) else $error("bad gnss code");
    chk_count_layout: assert property (MSG_VALID_OUT && MSG_FIRST_OUT |-> MSG_DATA_OUT[15:8] ==
        (MSG_DATA_OUT[31:24] == 8'h06 ? 8'h04 : MSG_DATA_OUT[31:24] inside {8'h01, 8'h02} ? 8'h08 : 8'h0A))
        else $error("word count does not fit layout");
    chk_last_count: assert property (MSG_VALID_OUT && MSG_LAST_OUT |-> !MSG_FIRST_OUT && pay_q == cnt_q - 8'h01)
        else $error("last flag off count");
    chk_no_early_end: assert property (MSG_VALID_OUT && !MSG_FIRST_OUT && !MSG_LAST_OUT |-> pay_q < cnt_q - 8'h01)
        else $error("payload runs past count");
    chk_word_holds: assert property (MSG_VALID_OUT && !MSG_READY_IN |=> MSG_VALID_OUT && $stable(MSG_DATA_OUT))
        else $error("report word not held");
    chk_busy_refuse: assert property (MSG_VALID_OUT |-> !SF_READY_OUT)
        else $error("decoder ready while reporting");
    chk_bds_padding: assert property (MSG_VALID_OUT && !MSG_FIRST_OUT && gnss_q == 8'h03 |->
        MSG_DATA_OUT[31:30] == 2'b00) else $error("beidou padding set");
    chk_glo_idle: assert property (MSG_VALID_OUT && !MSG_FIRST_OUT && gnss_q == 8'h06 && pay_q == 8'h00 |->
        !MSG_DATA_OUT[31]) else $error("glonass idle chip set");
    chk_drop_quiet: assert property (DROP_OUT |-> !MSG_VALID_OUT ##1 !DROP_OUT)
        else $error("drop not a lone pulse");
endmodule
bind nav_subframe_reporter nav_report_checker u_chk (
    .REF_CLK_IN(REF_CLK_IN), .RESET_N_IN(RESET_N_IN), .REPORT_EN_IN(REPORT_EN_IN),
    .SF_VALID_IN(SF_VALID_IN), .SF_READY_OUT(SF_READY_OUT), .SF_LAST_IN(SF_LAST_IN),
    .MSG_VALID_OUT(MSG_VALID_OUT), .MSG_READY_IN(MSG_READY_IN), .MSG_DATA_OUT(MSG_DATA_OUT),
    .MSG_FIRST_OUT(MSG_FIRST_OUT), .MSG_LAST_OUT(MSG_LAST_OUT), .DROP_OUT(DROP_OUT));

// file: nav_host_model.sv
// parser model: takes report words and keeps them for the bench
// assumes the framer holds each word until ready is seen high
`timescale 1ns/100ps
module nav_host_model
    import sf_report_pkg::*;
(
    input  wire logic              clk_in,        // clock
    input  wire logic              rst_n_in,      // reset, low
    input  wire logic              slow_in,       // stall every other cycle
    input  wire logic              clr_in,        // forget last message
    input  wire logic              valid_in,      // word valid
    input  wire logic [WORD_W-1:0] data_in,       // report word
    input  wire logic              first_in,      // header
    input  wire logic              last_in,       // final word
    output logic                   ready_out,     // take word
    output logic      [WORD_W-1:0] mem_out [0:10], // header then payload
    output int                     got_out,       // words taken
    output logic                   done_out       // message complete
);
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ready_out <= 1'b0;
            got_out   <= 0;
            done_out  <= 1'b0;
        end else begin
            ready_out <= slow_in ? !ready_out : 1'b1;
            if (clr_in) begin
                got_out  <= 0;
                done_out <= 1'b0;
            end else if (valid_in && ready_out) begin
                // stored raw: layout picked later from the id, padding judged later by the bench
                mem_out[first_in ? 0 : got_out] <= data_in;
                got_out  <= first_in ? 1 : got_out + 1;
                done_out <= last_in;
            end
        end
    end
endmodule

// file: nav_subframe_reporter_tb.sv
// bench: decoder stimulus, parser model, per-layout judgement of each report
// assumes framer, checker bind and parser model compiled first
`timescale 1ns/100ps
module nav_subframe_reporter_tb;
    import sf_report_pkg::*;
    logic              clk = 1'b0;
    logic              rst_n = 1'b0;
    logic              rep_en = 1'b1;
    logic              sf_valid = 1'b0;
    logic              sf_first = 1'b0;
    logic              sf_last = 1'b0;
    logic [WORD_W-1:0] sf_word = 32'h0;
    logic              par_ok = 1'b1;
    logic [7:0]        gnss = 8'h00;
    logic [7:0]        sig = 8'h00;
    logic              sv_known = 1'b1;
    logic              alert = 1'b0;
    logic              frm_ok = 1'b0;
    logic              slow = 1'b0;
    logic              clr = 1'b0;
    logic              sf_ready, msg_valid, msg_ready, msg_first, msg_last, drop, done;
    logic [WORD_W-1:0] msg_data;
    logic [WORD_W-1:0] mem [0:10];
    int                got;
    int                err_count = 0;
    int                check_count = 0;
    int                cyc = 0;
    always #25 clk = !clk;
    nav_subframe_reporter uut (.REF_CLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(1'b1), .REPORT_EN_IN(rep_en),
        .SF_VALID_IN(sf_valid), .SF_READY_OUT(sf_ready), .SF_FIRST_IN(sf_first), .SF_LAST_IN(sf_last),
        .SF_WORD_IN(sf_word), .SF_PARITY_OK_IN(par_ok), .GNSS_ID_IN(gnss), .SV_ID_IN(8'h11),
        .SV_KNOWN_IN(sv_known), .SIG_ID_IN(sig), .GAL_ALERT_IN(alert), .GLO_FRAME_IN(8'h2A),
        .GLO_FRAME_OK_IN(frm_ok), .GLO_SUPER_IN(8'h5A), .GLO_SUPER_OK_IN(!frm_ok), .MSG_VALID_OUT(msg_valid),
        .MSG_READY_IN(msg_ready), .MSG_DATA_OUT(msg_data), .MSG_FIRST_OUT(msg_first),
        .MSG_LAST_OUT(msg_last), .DROP_OUT(drop));
    nav_host_model host (.clk_in(clk), .rst_n_in(rst_n), .slow_in(slow), .clr_in(clr), .valid_in(msg_valid),
        .data_in(msg_data), .first_in(msg_first), .last_in(msg_last), .ready_out(msg_ready),
        .mem_out(mem), .got_out(got), .done_out(done));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [WORD_W-1:0] exp, input logic [WORD_W-1:0] seen);
        check_count++;
        if (seen !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    function automatic logic [WORD_W-1:0] raw(input int i, input logic [1:0] top);
        return {top, 26'h2F0A5C3, 4'(i)};
    endfunction
    // one subframe in, then the whole report judged; ok low means none expected
    task automatic run(input logic [7:0] g, input logic [7:0] s, input int n, input int bad,
                       input logic [1:0] top, input logic ok);
        logic [WORD_W-1:0] e;
        logic              dropped;
        int                cnt;
        dropped = 1'b0;
        cnt = g == 8'h06 ? 4 : (g inside {8'h01, 8'h02}) ? 8 : 10;
        @(posedge clk);
        gnss <= g;
        sig  <= s;
        clr  <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            clr      <= 1'b0;
            sf_valid <= 1'b1;
            sf_first <= i == 0;
            sf_last  <= i == n - 1;
            sf_word  <= raw(i, top);
            par_ok   <= i != bad;
        end
        @(posedge clk);
        sf_valid <= 1'b0;
        sf_last  <= 1'b0;
        for (int k = 0; k < 60 && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
            dropped |= drop === 1'b1;
        end
        repeat (3) @(posedge clk);
        chk("drop", {31'h0, !ok && rep_en}, {31'h0, dropped});
        chk("words", ok ? 32'(cnt + 1) : 32'h0, 32'(got));
        if (ok) begin
            chk("header", {g, (g == 8'h06 && !sv_known) ? 8'hFF : 8'h11, 8'(cnt), s}, mem[0]);
            for (int i = 0; i < cnt; i++) begin
                e = raw(i, top);
                // low nibble of a raw word is its index, so the prior word's bit0 is odd(i-1)
                if (g inside {8'h00, 8'h05} && s == 8'h00 && i > 0 && !i[0])
                    e[29:6] = ~e[29:6];
                if (g == 8'h03)
                    e[31:30] = 2'b00;
                if (g == 8'h02 && alert && (i == 0 || i == 4))
                    e[30] = 1'b1;
                if (g == 8'h06 && i == 3)
                    e = {8'h00, frm_ok ? 8'h00 : 8'h5A, 8'h00, frm_ok ? 8'h2A : 8'h00};
                chk("payload", e, mem[i + 1]);
            end
        end
    endtask
    task automatic t_gps();
        slow <= 1'b1;
        run(GNSS_GPS, 8'h00, 10, 99, 2'b00, 1'b1);
        slow <= 1'b0;
    endtask
    task automatic t_l2c();
        run(GNSS_GPS, 8'h04, 10, 99, 2'b00, 1'b1);
    endtask
    task automatic t_qzss();
        run(GNSS_QZSS, 8'h00, 10, 99, 2'b00, 1'b1);
    endtask
    task automatic t_glo();
        sv_known <= 1'b0;
        frm_ok   <= 1'b1;
        run(GNSS_GLO, 8'h00, 3, 99, 2'b00, 1'b1);
        run(GNSS_GLO, 8'h00, 3, 99, 2'b10, 1'b0);
        frm_ok   <= 1'b0;
        run(GNSS_GLO, 8'h00, 3, 99, 2'b00, 1'b1);
        sv_known <= 1'b1;
    endtask
    task automatic t_bds();
        run(GNSS_BDS, 8'h00, 10, 99, 2'b11, 1'b1);
    endtask
    task automatic t_gal();
        run(GNSS_GAL, 8'h01, 8, 99, 2'b00, 1'b1);
        alert <= 1'b1;
        run(GNSS_GAL, 8'h01, 8, 99, 2'b00, 1'b1);
        alert <= 1'b0;
    endtask
    task automatic t_sbas();
        run(GNSS_SBAS, 8'h00, 8, 99, 2'b00, 1'b1);
    endtask
    task automatic t_faults();
        run(GNSS_GPS, 8'h00, 10, 9, 2'b00, 1'b0);
        run(GNSS_GPS, 8'h00, 9, 99, 2'b00, 1'b0);
        rep_en <= 1'b0;
        run(GNSS_GPS, 8'h00, 10, 99, 2'b00, 1'b0);
        rep_en <= 1'b1;
    endtask
    // cuts a hang short; the full run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_gps();
        t_l2c();
        t_qzss();
        t_glo();
        t_bds();
        t_gal();
        t_sbas();
        t_faults();
        print_verdict();
    end
endmodule
